/* File: fbio_defines.svh */
// Offsets, field positions, reset values and counts of the I/O image block
`ifndef FBIO_DEFINES_SVH
`define FBIO_DEFINES_SVH

// Output image, written by the host
`define FBIO_OFF_MOD_CMD   9'h000
`define FBIO_OFF_HS_REQ    9'h001
`define FBIO_OFF_BT_OUT    9'h002
`define FBIO_OFF_BT_IN     9'h003
// Input image, read by the host
`define FBIO_OFF_HS_ACK    9'h001
`define FBIO_OFF_STN3      9'h04c
`define FBIO_OFF_ALM_STAT  9'h050
`define FBIO_OFF_ALM_CNT   9'h051
`define FBIO_OFF_ALM_ADDR  9'h052
`define FBIO_OFF_ALM_SLOT  9'h053
`define FBIO_OFF_ALM_SEQ   9'h054
`define FBIO_OFF_ALM_KIND  9'h055
`define FBIO_OFF_ALM_QUAL  9'h056
`define FBIO_OFF_ALM_RSVD  9'h057
`define FBIO_OFF_IN_FIRST  9'h058
`define FBIO_OFF_IN_LAST   9'h1ef
`define FBIO_IN_PAGE_BYTES 25'h0000198
// Field positions
`define FBIO_BIT_HOST_NOT_READY      5
`define FBIO_BIT_COLD      7
`define FBIO_BIT_PEND      0
`define FBIO_BIT_LOST      7
`define FBIO_BIT_DIAG_OVF  7
`define FBIO_BIT_ACK_DIAG  0
`define FBIO_BIT_ACK_GLOB  1
// Field limits
`define FBIO_MAX_ADDR      8'h7e
`define FBIO_MAX_SLOT      8'hfe
`define FBIO_MAX_SEQ       8'h1f
`define FBIO_MAX_QUAL      8'h07
`define FBIO_KIND_LO_MAX   8'h06
`define FBIO_KIND_HI_MIN   8'h20
`define FBIO_KIND_HI_MAX   8'h7e
// Reset values and counts
`define FBIO_RST_BYTE      8'h00
`define FBIO_RST_WORD      16'h0000
`define FBIO_BOOT_CYCLES   4'hf

`endif

/* File: fbio_engine_model.sv */
// Fieldbus engine model: paged input bytes and handshake completion
`timescale 1ns/1ps
`default_nettype none

module fbio_engine_model
#(
  parameter int DIAG_LAT = 3,
  parameter int GLOB_LAT = 20
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        in_data_req,
  input  wire logic [24:0] in_data_addr,
  output var  logic [7:0]  in_data_byte,
  input  wire logic        diag_req_start,
  output var  logic        diag_done,
  input  wire logic        glob_req_start,
  output var  logic        glob_done
);
  logic [7:0] last_ff = 8'h00;
  int         dcnt_ff = 0;
  int         gcnt_ff = 0;

  // Linear input byte; an idle bus shows the inverse of the last byte
  always_comb
    in_data_byte = in_data_req ? (in_data_addr[7:0] ^ in_data_addr[15:8] ^ 8'h3c) : ~last_ff;

  always_ff @(posedge mclk)
    if (in_data_req)
      last_ff <= in_data_byte;

  // Fast completion of diagnostic requests
  always_ff @(posedge mclk)
  begin
    diag_done <= (dcnt_ff == 1);
    if (sys_rst)
      dcnt_ff <= 0;
    else if (diag_req_start)
      dcnt_ff <= DIAG_LAT;
    else if (dcnt_ff > 0)
      dcnt_ff <= dcnt_ff - 1;
  end

  // Slow completion of global-control requests
  always_ff @(posedge mclk)
  begin
    glob_done <= (gcnt_ff == 1);
    if (sys_rst)
      gcnt_ff <= 0;
    else if (glob_req_start)
      gcnt_ff <= GLOB_LAT;
    else if (gcnt_ff > 0)
      gcnt_ff <= gcnt_ff - 1;
  end

endmodule // fbio_engine_model

`default_nettype wire

/* File: fbio_fifo.sv */
// Alarm queue with registered head word
`timescale 1ns/1ps
`default_nettype none

module fbio_fifo
#(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
)
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 2);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    mem_cnt_ff;
  logic [CW-1:0]    nxt_mem_cnt;
  logic             push;
  logic             load;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Total occupancy counts the head register, so DEPTH words fit in all
  assign push = in_valid && in_ready;
  assign load = (mem_cnt_ff != '0) && (!out_valid || out_ready);
  assign nxt_mem_cnt = mem_cnt_ff + CW'(push) - CW'(load);

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      mem_cnt_ff <= '0;
      in_ready   <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (load)
      begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      mem_cnt_ff <= nxt_mem_cnt;
      in_ready   <= (nxt_mem_cnt + CW'(load || (out_valid && !out_ready))) < CW'(DEPTH);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_ff];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule : fbio_fifo

`default_nettype wire

/* File: fbio_image_ctrl.sv */
// Station status, alarm indication and command image of the fieldbus master
`timescale 1ns/1ps
`default_nettype none
`include "fbio_defines.svh"

module fbio_image_ctrl
  import fbio_pkg::*;
#(
  parameter int ALARM_DEPTH = 32,
  parameter int IN_ADDR_W   = 25
)
(
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Host image access
  input  wire logic                 host_wr_en,
  input  wire logic [8:0]           host_wr_addr,
  input  wire logic [15:0]          host_wr_data,
  input  wire logic                 host_rd_en,
  input  wire logic [8:0]           host_rd_addr,
  output var  logic [7:0]           host_rd_data,
  output var  logic                 host_rd_valid,
  input  wire logic                 host_alarm_ack,
  // Alarms from the fieldbus engine
  input  wire logic                 alm_in_valid,
  output var  logic                 alm_in_ready,
  input  wire logic [7:0]           alm_in_addr,
  input  wire logic [7:0]           alm_in_slot,
  input  wire logic [7:0]           alm_in_seq,
  input  wire logic [7:0]           alm_in_kind,
  input  wire logic [7:0]           alm_in_qual,
  input  wire logic                 diag_overflow_in,
  // Paged input data from the fieldbus engine
  output var  logic                 in_data_req,
  output var  logic [IN_ADDR_W-1:0] in_data_addr,
  input  wire logic [7:0]           in_data_byte,
  // Handshake commands
  output var  logic                 diag_req_start,
  input  wire logic                 diag_done,
  output var  logic                 glob_req_start,
  input  wire logic                 glob_done,
  // Bus control
  output var  logic                 bus_run,
  output var  logic                 fail_safe,
  output var  logic                 cold_boot
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [7:0]           module_command_bits_ff;
  logic [7:0]           handshake_request_bits_ff;
  logic [15:0]          block_transfer_out_index_ff;
  logic [15:0]          block_transfer_in_index_ff;
  logic                 cold_prev_ff;
  logic                 cold_edge;
  fbio_bus_t            bus_state_ff;
  fbio_bus_t            nxt_bus_state;
  logic [3:0]           boot_cnt_ff;
  logic                 boot_clear;
  logic                 diag_overflow_flag_ff;
  fbio_alm_t            alm_state_ff;
  fbio_alarm_t          alm_in_rec;
  fbio_alarm_t          alm_head;
  fbio_alarm_t          alm_cur_ff;
  logic                 alm_head_valid;
  logic                 alm_pop;
  logic                 alm_push_ok;
  logic                 alarm_lost_flag_ff;
  logic [7:0]           alarm_counter_ff;
  logic [1:0]           ack_bits_ff;
  logic [1:0]           sent_bits_ff;
  logic [1:0]           busy_bits_ff;
  logic [1:0]           start_ff;
  logic [1:0]           done_in;
  logic                 rd_pend_ff;
  logic [8:0]           rd_addr_ff;
  logic [7:0]           nxt_rd_data;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic alarm_ok(input fbio_alarm_t a);
    logic kind_ok;
    kind_ok = ((a.kind != 8'h00) && (a.kind <= `FBIO_KIND_LO_MAX))
           || ((a.kind >= `FBIO_KIND_HI_MIN) && (a.kind <= `FBIO_KIND_HI_MAX));
    alarm_ok = (a.addr <= `FBIO_MAX_ADDR) && (a.slot <= `FBIO_MAX_SLOT)
            && (a.seq <= `FBIO_MAX_SEQ) && (a.qual <= `FBIO_MAX_QUAL)
            && kind_ok;
  endfunction

  function automatic logic in_data_range(input logic [8:0] a);
    in_data_range = (a >= `FBIO_OFF_IN_FIRST) && (a <= `FBIO_OFF_IN_LAST);
  endfunction

  // Linear engine address of an input byte within the selected page
  function automatic logic [IN_ADDR_W-1:0] lin_addr(input logic [15:0] page,
                                                   input logic [8:0]  a);
    logic [IN_ADDR_W-1:0] base;
    base = IN_ADDR_W'(page) * IN_ADDR_W'(`FBIO_IN_PAGE_BYTES);
    lin_addr = base + IN_ADDR_W'(a - `FBIO_OFF_IN_FIRST);
  endfunction

  // ****************************************************
  // Output image registers
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      module_command_bits_ff      <= `FBIO_RST_BYTE;
      handshake_request_bits_ff   <= `FBIO_RST_BYTE;
      block_transfer_out_index_ff <= `FBIO_RST_WORD;
      block_transfer_in_index_ff  <= `FBIO_RST_WORD;
    end
    else if (host_wr_en)
    begin
      unique case (host_wr_addr)
        `FBIO_OFF_MOD_CMD: module_command_bits_ff      <= host_wr_data[7:0];
        `FBIO_OFF_HS_REQ:  handshake_request_bits_ff   <= host_wr_data[7:0];
        `FBIO_OFF_BT_OUT:  block_transfer_out_index_ff <= host_wr_data;
        `FBIO_OFF_BT_IN:   block_transfer_in_index_ff  <= host_wr_data;
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************
  // Bus state and cold boot
  // ****************************************************
  assign cold_edge  = module_command_bits_ff[`FBIO_BIT_COLD] && !cold_prev_ff;
  assign boot_clear = (bus_state_ff == FBIO_BUS_BOOT);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cold_prev_ff <= 1'b0;
    end
    else
    begin
      cold_prev_ff <= module_command_bits_ff[`FBIO_BIT_COLD];
    end
  end

  always_comb
  begin
    nxt_bus_state = bus_state_ff;
    unique case (bus_state_ff)
      FBIO_BUS_STOP:
      begin
        if (!module_command_bits_ff[`FBIO_BIT_HOST_NOT_READY])
        begin
          nxt_bus_state = FBIO_BUS_RUN;
        end
      end
      FBIO_BUS_RUN:
      begin
        if (module_command_bits_ff[`FBIO_BIT_HOST_NOT_READY])
        begin
          nxt_bus_state = FBIO_BUS_STOP;
        end
      end
      FBIO_BUS_BOOT:
      begin
        if (boot_cnt_ff == `FBIO_BOOT_CYCLES)
        begin
          nxt_bus_state = FBIO_BUS_STOP;
        end
      end
    endcase
    if (cold_edge)
    begin
      nxt_bus_state = FBIO_BUS_BOOT;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_state_ff <= FBIO_BUS_STOP;
      boot_cnt_ff  <= 4'h0;
    end
    else
    begin
      bus_state_ff <= nxt_bus_state;
      boot_cnt_ff  <= (nxt_bus_state == FBIO_BUS_BOOT) ? boot_cnt_ff + 4'h1 : 4'h0;
    end
  end

  // Slaves are held fail-safe whenever the bus is not running
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_run   <= 1'b0;
      fail_safe <= 1'b1;
      cold_boot <= 1'b0;
    end
    else
    begin
      bus_run   <= (nxt_bus_state == FBIO_BUS_RUN);
      fail_safe <= (nxt_bus_state != FBIO_BUS_RUN);
      cold_boot <= cold_edge;
    end
  end

  // ****************************************************
  // Station status
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      diag_overflow_flag_ff <= 1'b0;
    end
    else
    begin
      diag_overflow_flag_ff <= diag_overflow_in;
    end
  end

  // ****************************************************
  // Alarm queue
  // ****************************************************
  assign alm_in_rec  = '{addr: alm_in_addr, slot: alm_in_slot, seq: alm_in_seq,
                         kind: alm_in_kind, qual: alm_in_qual};
  // Out-of-range alarms and alarms arriving with the bus down are dropped
  assign alm_push_ok = alm_in_valid && alarm_ok(alm_in_rec)
                    && (bus_state_ff == FBIO_BUS_RUN);
  // A new head becomes pending when none is shown or the shown one is acked
  assign alm_pop = alm_head_valid
                && ((alm_state_ff == FBIO_ALM_IDLE) || host_alarm_ack);

  fbio_fifo
  #(
    .WIDTH ($bits(fbio_alarm_t)),
    .DEPTH (ALARM_DEPTH - 1)
  )
  u_alarm_fifo
  (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (boot_clear),
    .in_valid  (alm_push_ok),
    .in_ready  (alm_in_ready),
    .in_data   (alm_in_rec),
    .out_valid (alm_head_valid),
    .out_ready (alm_pop),
    .out_data  (alm_head)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      alm_state_ff <= FBIO_ALM_IDLE;
    end
    else if (alm_pop)
    begin
      alm_state_ff <= FBIO_ALM_PEND;
    end
    else if (host_alarm_ack)
    begin
      alm_state_ff <= FBIO_ALM_IDLE;
    end
  end

  // Detail fields keep their last values after the final acknowledge
  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      alm_cur_ff <= '0;
    end
    else if (alm_pop)
    begin
      alm_cur_ff <= alm_head;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      alarm_counter_ff <= `FBIO_RST_BYTE;
    end
    else if (alm_pop)
    begin
      alarm_counter_ff <= alarm_counter_ff + 8'h01;
    end
  end

  // Loss while full wins over the clear of a stopped bus
  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      alarm_lost_flag_ff <= 1'b0;
    end
    else if (alm_push_ok && !alm_in_ready)
    begin
      alarm_lost_flag_ff <= 1'b1;
    end
    else if (bus_state_ff != FBIO_BUS_RUN)
    begin
      alarm_lost_flag_ff <= 1'b0;
    end
  end

  // ****************************************************
  // Handshake requests
  // ****************************************************
  assign done_in = {glob_done, diag_done};

  always_ff @(posedge mclk)
  begin
    if (sys_rst || boot_clear)
    begin
      ack_bits_ff  <= 2'h0;
      sent_bits_ff <= 2'h0;
      busy_bits_ff <= 2'h0;
      start_ff     <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        start_ff[i] <= 1'b0;
        if (busy_bits_ff[i])
        begin
          if (done_in[i])
          begin
            ack_bits_ff[i]  <= sent_bits_ff[i];
            busy_bits_ff[i] <= 1'b0;
          end
        end
        else if (handshake_request_bits_ff[i] != ack_bits_ff[i])
        begin
          sent_bits_ff[i] <= handshake_request_bits_ff[i];
          busy_bits_ff[i] <= 1'b1;
          start_ff[i]     <= 1'b1;
        end
      end
    end
  end

  assign diag_req_start = start_ff[`FBIO_BIT_ACK_DIAG];
  assign glob_req_start = start_ff[`FBIO_BIT_ACK_GLOB];

  // ****************************************************
  // Input image read
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_pend_ff   <= 1'b0;
      rd_addr_ff   <= 9'h000;
      in_data_req  <= 1'b0;
      in_data_addr <= '0;
    end
    else
    begin
      rd_pend_ff  <= host_rd_en;
      rd_addr_ff  <= host_rd_addr;
      in_data_req <= host_rd_en && in_data_range(host_rd_addr);
      if (host_rd_en && in_data_range(host_rd_addr))
      begin
        in_data_addr <= lin_addr(block_transfer_in_index_ff, host_rd_addr);
      end
    end
  end

  always_comb
  begin
    nxt_rd_data = 8'h00;
    unique case (rd_addr_ff)
      `FBIO_OFF_HS_ACK:   nxt_rd_data = {6'h00, ack_bits_ff};
      `FBIO_OFF_STN3:     nxt_rd_data = {diag_overflow_flag_ff, 7'h00};
      `FBIO_OFF_ALM_STAT:
      begin
        nxt_rd_data[`FBIO_BIT_PEND] = (alm_state_ff == FBIO_ALM_PEND);
        nxt_rd_data[`FBIO_BIT_LOST] = alarm_lost_flag_ff;
      end
      `FBIO_OFF_ALM_CNT:  nxt_rd_data = alarm_counter_ff;
      `FBIO_OFF_ALM_ADDR: nxt_rd_data = alm_cur_ff.addr;
      `FBIO_OFF_ALM_SLOT: nxt_rd_data = alm_cur_ff.slot;
      `FBIO_OFF_ALM_SEQ:  nxt_rd_data = alm_cur_ff.seq;
      `FBIO_OFF_ALM_KIND: nxt_rd_data = alm_cur_ff.kind;
      `FBIO_OFF_ALM_QUAL: nxt_rd_data = alm_cur_ff.qual;
      default:
      begin
        if (in_data_range(rd_addr_ff))
        begin
          nxt_rd_data = in_data_byte;
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      host_rd_data  <= 8'h00;
      host_rd_valid <= 1'b0;
    end
    else
    begin
      host_rd_valid <= rd_pend_ff;
      if (rd_pend_ff)
      begin
        host_rd_data <= nxt_rd_data;
      end
    end
  end

endmodule : fbio_image_ctrl

`default_nettype wire

/* File: fbio_image_ctrl_chk.sv */
// Port checker of the I/O image block
`timescale 1ns/1ps
`default_nettype none

module fbio_image_ctrl_chk
#(
  parameter int ALARM_DEPTH = 32,
  parameter int IN_ADDR_W   = 25
)
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        host_wr_en,
  input wire logic [8:0]  host_wr_addr,
  input wire logic [15:0] host_wr_data,
  input wire logic        host_rd_en,
  input wire logic [8:0]  host_rd_addr,
  input wire logic        host_rd_valid,
  input wire logic        in_data_req,
  input wire logic        diag_req_start,
  input wire logic        glob_req_start,
  input wire logic        bus_run,
  input wire logic        fail_safe,
  input wire logic        cold_boot
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rd_answer: assert property (host_rd_en |-> ##2 host_rd_valid)
    else $error("read answer late");
  a_in_fetch: assert property (host_rd_en && host_rd_addr >= 9'h058 && host_rd_addr <= 9'h1ef
    |=> in_data_req)
    else $error("input byte not fetched");
  a_in_cause: assert property (in_data_req |-> $past(host_rd_en) && $past(host_rd_addr) >= 9'h058)
    else $error("input fetch without read");
  a_safe_inverse: assert property (fail_safe == !bus_run)
    else $error("fail safe not inverse of run");
  a_host_not_ready_stop: assert property (host_wr_en && host_wr_addr == 9'h000 && host_wr_data[5]
    |-> ##3 !bus_run)
    else $error("bus runs while not ready");
  a_cold_down: assert property (cold_boot |=> !bus_run [*8])
    else $error("bus runs during cold boot");
  a_diag_pulse: assert property (diag_req_start |=> !diag_req_start)
    else $error("diag start longer than a cycle");
  a_glob_pulse: assert property (glob_req_start |=> !glob_req_start)
    else $error("global start longer than a cycle");

endmodule // fbio_image_ctrl_chk

`default_nettype wire

/* File: fbio_image_ctrl_tb.sv */
// Testbench of the I/O image block
`timescale 1ns/1ps
`default_nettype none

module fbio_image_ctrl_tb;
  import fbio_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, host_wr_en = 1'b0, host_rd_en = 1'b0;
  logic        host_alarm_ack = 1'b0, alm_in_valid = 1'b0, diag_overflow_in = 1'b0;
  logic [8:0]  host_wr_addr = 9'h000, host_rd_addr = 9'h000;
  logic [15:0] host_wr_data = 16'h0000;
  fbio_alarm_t alm = '0;
  logic [7:0]  host_rd_data, in_data_byte, cnt;
  logic        host_rd_valid, alm_in_ready, in_data_req, diag_req_start, diag_done;
  logic        glob_req_start, glob_done, bus_run, fail_safe, cold_boot;
  logic [24:0] in_data_addr;
  int          fails = 0, total_checks = 0;

  always #2 mclk = ~mclk;

  fbio_image_ctrl i_dut (.mclk, .sys_rst, .host_wr_en, .host_wr_addr, .host_wr_data,
    .host_rd_en, .host_rd_addr, .host_rd_data, .host_rd_valid, .host_alarm_ack,
    .alm_in_valid, .alm_in_ready, .alm_in_addr(alm.addr), .alm_in_slot(alm.slot),
    .alm_in_seq(alm.seq), .alm_in_kind(alm.kind), .alm_in_qual(alm.qual), .diag_overflow_in,
    .in_data_req, .in_data_addr, .in_data_byte, .diag_req_start, .diag_done, .glob_req_start,
    .glob_done, .bus_run, .fail_safe, .cold_boot);
  fbio_engine_model i_eng (.mclk, .sys_rst, .in_data_req, .in_data_addr, .in_data_byte,
    .diag_req_start, .diag_done, .glob_req_start, .glob_done);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    host_wr_en   = 1'b1;
    host_wr_addr = a;
    host_wr_data = d;
    cyc(1);
    host_wr_en = 1'b0;
  endtask

  task automatic rc(input logic [8:0] a, input logic [7:0] e, input string n);
    int i;
    host_rd_en   = 1'b1;
    host_rd_addr = a;
    cyc(1);
    host_rd_en = 1'b0;
    for (i = 0; i < 4 && host_rd_valid !== 1'b1; i++)
      cyc(1);
    if (i == 4)
    begin
      fails++;
      stop_test();
    end
    chk(n, host_rd_data, e);
  endtask

  task automatic send(input fbio_alarm_t r);
    alm          = r;
    alm_in_valid = 1'b1;
    cyc(1);
  endtask

  task automatic ackp;
    host_alarm_ack = 1'b1;
    cyc(1);
    host_alarm_ack = 1'b0;
    cyc(2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_status;
    diag_overflow_in = 1'b1;
    cyc(1);
    rc(9'h04c, 8'h80, "station_status_third");
    diag_overflow_in = 1'b0;
    rc(9'h057, 8'h00, "alarm_reserved");
    rc(9'h001, 8'h00, "handshake_acknowledge_bits");
    rc(9'h1f4, 8'h00, "unmapped");
  endtask

  task automatic t_cold;
    wr(9'h000, 16'h0080);
    cyc(1);
    chk("cold_boot", {7'h00, cold_boot}, 8'h01);
    cyc(1);
    chk("bus_run", {7'h00, bus_run}, 8'h00);
    wr(9'h000, 16'h0000);
    cyc(25);
    rc(9'h051, 8'h00, "alarm_counter");
    chk("bus_run", {7'h00, bus_run}, 8'h01);
    cnt = 8'h00;
  endtask

  task automatic t_alarm;
    send('{8'h7e, 8'hfe, 8'h1f, 8'h06, 8'h07});
    send('{8'h00, 8'h00, 8'h00, 8'h20, 8'h00});
    alm_in_valid = 1'b0;
    cyc(5);
    rc(9'h050, 8'h01, "alarm_status");
    rc(9'h051, cnt + 8'h01, "alarm_counter");
    rc(9'h052, 8'h7e, "alarm_source_address");
    rc(9'h053, 8'hfe, "alarm_slot");
    rc(9'h054, 8'h1f, "alarm_sequence");
    rc(9'h055, 8'h06, "alarm_kind");
    rc(9'h056, 8'h07, "alarm_qualifier");
    ackp();
    rc(9'h050, 8'h01, "alarm_status");
    rc(9'h055, 8'h20, "alarm_kind");
    rc(9'h051, cnt + 8'h02, "alarm_counter");
    ackp();
    rc(9'h050, 8'h00, "alarm_status");
    rc(9'h055, 8'h20, "alarm_kind");
    send('{8'h01, 8'h01, 8'h01, 8'h07, 8'h01});
    alm_in_valid = 1'b0;
    cyc(5);
    rc(9'h050, 8'h00, "alarm_status");
    cnt = cnt + 8'h02;
  endtask

  task automatic t_overrun;
    for (int i = 0; i < 34; i++)
      send('{i[7:0], i[7:0], {3'h0, i[4:0]}, 8'h20 + i[7:0], {5'h00, i[2:0]}});
    alm_in_valid = 1'b0;
    cyc(5);
    rc(9'h050, 8'h81, "alarm_status");
    chk("alm_in_ready", {7'h00, alm_in_ready}, 8'h00);
    repeat (31)
      ackp();
    rc(9'h050, 8'h81, "alarm_status");
    rc(9'h052, 8'h1f, "alarm_source_address");
    chk("alm_in_ready", {7'h00, alm_in_ready}, 8'h01);
    ackp();
    rc(9'h050, 8'h80, "alarm_status");
    rc(9'h051, cnt + 8'h20, "alarm_counter");
    cnt = cnt + 8'h20;
    wr(9'h000, 16'h0020);
    cyc(4);
    chk("fail_safe", {7'h00, fail_safe}, 8'h01);
    rc(9'h050, 8'h00, "alarm_status");
    wr(9'h000, 16'h0000);
    cyc(4);
  endtask

  task automatic t_wrap;
    repeat (256)
    begin
      send('{8'h05, 8'h05, 8'h05, 8'h01, 8'h05});
      alm_in_valid = 1'b0;
      cyc(4);
      ackp();
    end
    rc(9'h051, cnt, "alarm_counter");
  endtask

  task automatic t_hs;
    wr(9'h001, 16'h0001);
    rc(9'h001, 8'h00, "handshake_acknowledge_bits");
    cyc(30);
    rc(9'h001, 8'h01, "handshake_acknowledge_bits");
    wr(9'h001, 16'h0003);
    cyc(30);
    rc(9'h001, 8'h03, "handshake_acknowledge_bits");
    wr(9'h001, 16'h0000);
    cyc(30);
    rc(9'h001, 8'h00, "handshake_acknowledge_bits");
  endtask

  task automatic t_input;
    wr(9'h003, 16'h0001);
    rc(9'h058, 8'h98 ^ 8'h01 ^ 8'h3c, "input_first");
    rc(9'h1ef, 8'h2f ^ 8'h03 ^ 8'h3c, "input_last");
    wr(9'h003, 16'h0000);
    rc(9'h059, 8'h01 ^ 8'h3c, "input_page0");
  endtask

  initial
  begin
    cyc(3);
    sys_rst = 1'b0;
    cyc(3);
    t_status();
    t_cold();
    t_alarm();
    t_overrun();
    t_wrap();
    t_hs();
    t_input();
    stop_test();
  end

endmodule // fbio_image_ctrl_tb

bind fbio_image_ctrl fbio_image_ctrl_chk #(.ALARM_DEPTH(ALARM_DEPTH), .IN_ADDR_W(IN_ADDR_W))
  i_chk (.mclk, .sys_rst, .host_wr_en, .host_wr_addr, .host_wr_data, .host_rd_en,
  .host_rd_addr, .host_rd_valid, .in_data_req, .diag_req_start, .glob_req_start, .bus_run,
  .fail_safe, .cold_boot);

`default_nettype wire

/* File: fbio_pkg.sv */
// Types shared by the I/O image block
package fbio_pkg;

  typedef enum logic [1:0] {FBIO_BUS_STOP, FBIO_BUS_RUN, FBIO_BUS_BOOT} fbio_bus_t;

  typedef enum logic {FBIO_ALM_IDLE, FBIO_ALM_PEND} fbio_alm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] slot;
    logic [7:0] seq;
    logic [7:0] kind;
    logic [7:0] qual;
  } fbio_alarm_t;

endpackage : fbio_pkg
